//--- design/pcs_sequencer.sv
// PSU control-signal sequencer: main output, power-good and alert
// Overview of operation
// - Main output turns on only with unplug sense low and enable low.
// - Enable high or undriven turns off everything but standby.
// - An undriven enable input reads as high, the off state.
// - Unplug sense high or undriven shuts the main output regardless.
// - Main output is off within 100 us of unplug sense going high.
// - Outputs reach regulation between 5 ms and 400 ms after enable.
// - Power-good goes low within 50 ms of enable being released.
// - Power-good is high only while all outputs are in regulation.
// - Power-good drops on undervoltage, internal failure or lost input.
// - Power-good rises 100 ms to 500 ms after 12 V is in regulation.
// - The power-good delay counter stays at zero during current limit while power-good is low.
// - Outputs stay regulated 1 ms to 200 ms after power-good falls.
// - Alert is raised for temperature, failure, OC, OV, UV or fan.
// - Alert may also report end of life or out-of-spec environment.
// - Power-good stays low at least 100 ms across an off/on cycle.
`timescale 1ns/100ps
`default_nettype none
module pcs_sequencer
    import pcs_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable_n,
    input wire logic enable_driven,
    input wire logic unplug_sense,
    input wire logic sense_driven,
    input wire logic main_in_reg,
    input wire logic current_limit,
    input wire logic internal_fail,
    input wire logic input_lost,
    input wire logic temp_warn,
    input wire logic general_fail,
    input wire logic over_current,
    input wire logic over_voltage,
    input wire logic under_voltage,
    input wire logic fan_fail,
    input wire logic end_of_life,
    input wire logic env_exceeded,
    input wire logic opt_alert_en,
    output logic main_on,
    output logic output_good_alias,
    output logic fault_alert_n
);

    function automatic logic st_drives_main(input pcs_state_t st);
        return (st == ST_RAMP) || (st == ST_RUN) || (st == ST_HOLD);
    endfunction : st_drives_main

    pcs_state_t state;
    pcs_state_t next_state;
    logic ms_tick;
    logic [MS_W-1:0] ms_cnt;
    logic [MS_W-1:0] good_cnt;
    logic en_active;
    logic kill_eff;
    logic on_request;
    logic good_fault;
    logic alert_cond;

    pcs_tick_div #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .ms_tick(ms_tick)
    );

    // Pad pull-ups: an undriven pin reads as its high level, the one that keeps main off
    assign en_active = enable_driven & ~enable_n;
    assign kill_eff = ~sense_driven | unplug_sense;
    assign on_request = en_active & ~kill_eff;
    assign good_fault = ~main_in_reg | internal_fail | input_lost;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (on_request) begin
                    next_state = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (!on_request) begin
                    next_state = ST_OFF;
                end else if (ms_tick && ms_cnt == T_ON_MIN_MS) begin
                    next_state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (kill_eff) begin
                    next_state = ST_OFF;
                end else if (!en_active) begin
                    next_state = ST_HOLD;
                end else if (main_in_reg) begin
                    next_state = ST_RUN;
                end else if (ms_tick && ms_cnt == T_ON_MAX_MS - 10'h001) begin
                    next_state = ST_FAULT;
                end
            end
            ST_RUN: begin
                if (kill_eff) begin
                    next_state = ST_OFF;
                end else if (!en_active) begin
                    next_state = ST_HOLD;
                end else if (internal_fail) begin
                    next_state = ST_FAULT;
                end
            end
            ST_HOLD: begin
                // Main stays up briefly so power-good falls first
                if (kill_eff) begin
                    next_state = ST_OFF;
                end else if (ms_tick && ms_cnt == T_HOLD_MS) begin
                    next_state = ST_OFF;
                end
            end
            ST_FAULT: begin
                // Latched off until the system releases enable
                if (!en_active) begin
                    next_state = ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Kill acts through next_state, so main drops one clock later
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_on <= 1'b0;
        end else begin
            main_on <= st_drives_main(next_state);
        end
    end

    // Enable-to-regulation and hold-off timer, kept across SOFT to RAMP
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ms_cnt <= '0;
        end else if (state == ST_OFF || state == ST_FAULT ||
                     (state != ST_HOLD && next_state == ST_HOLD)) begin
            ms_cnt <= '0;
        end else if (ms_tick && ms_cnt != MS_CNT_MAX) begin
            ms_cnt <= ms_cnt + 10'h001;
        end
    end

    // Power-good delay counts only in RUN and restarts after any drop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            good_cnt <= '0;
        end else if (state != ST_RUN || good_fault) begin
            good_cnt <= '0;
        end else if (current_limit && !output_good_alias) begin
            good_cnt <= '0;
        end else if (ms_tick && good_cnt != T_GOOD_DLY_MS) begin
            good_cnt <= good_cnt + 10'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            output_good_alias <= 1'b0;
        end else if (state != ST_RUN || next_state != ST_RUN ||
                     good_fault) begin
            output_good_alias <= 1'b0;
        end else if (good_cnt == T_GOOD_DLY_MS) begin
            output_good_alias <= 1'b1;
        end
    end

    assign alert_cond = temp_warn | general_fail | over_current |
                        over_voltage | under_voltage | fan_fail |
                        (state == ST_FAULT) |
                        (opt_alert_en & (end_of_life | env_exceeded));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_alert_n <= 1'b1;
        end else begin
            fault_alert_n <= ~alert_cond;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_on_needs_request: assert property (
        $rose(main_on) |-> $past(on_request) && $past(ms_cnt) == T_ON_MIN_MS)
        else $error("main output rose without a valid request");

    chk_enable_off_main: assert property (
        !en_active && !main_on |=> !main_on)
        else $error("main output turned on with enable released");

    chk_undriven_enable: assert property (
        !enable_driven && state == ST_OFF |=> state == ST_OFF)
        else $error("undriven enable left the off state");

    chk_kill_drops_main: assert property (
        kill_eff |=> !main_on && !output_good_alias)
        else $error("main output still on after unplug sense");

    chk_kill_time: assert property (
        $rose(kill_eff) |-> ##[1:2] !main_on)
        else $error("main output not off within the unplug bound");

    chk_ramp_bound: assert property (
        state == ST_RAMP |-> ms_cnt < T_ON_MAX_MS)
        else $error("regulation wait exceeded its upper bound");

    chk_good_release: assert property (
        output_good_alias && !en_active |=> !output_good_alias)
        else $error("power-good stayed high after enable release");

    chk_good_in_reg: assert property (
        output_good_alias |-> $past(main_in_reg) && state == ST_RUN)
        else $error("power-good high while out of regulation");

    chk_good_faults: assert property (
        internal_fail || input_lost |=> !output_good_alias)
        else $error("power-good high during a fault");

    chk_good_delay: assert property (
        $rose(output_good_alias) |-> $past(good_cnt) == T_GOOD_DLY_MS &&
        T_GOOD_DLY_MS > T_GOOD_MIN_MS && T_GOOD_DLY_MS < T_GOOD_MAX_MS)
        else $error("power-good rose at the wrong delay");

    chk_limit_holds: assert property (
        current_limit && !output_good_alias |=> good_cnt == '0)
        else $error("power-good delay advanced in current limit");

    chk_hold_window: assert property (
        state == ST_HOLD |-> !output_good_alias && main_on &&
        ms_cnt <= T_HOLD_MS && T_HOLD_MS >= T_HOLD_MIN_MS)
        else $error("hold-off after power-good fall out of window");

    chk_alert_raise: assert property (
        over_current || fan_fail || under_voltage |=> !fault_alert_n)
        else $error("alert not raised for a fault");

    chk_alert_release: assert property (
        !alert_cond |=> fault_alert_n)
        else $error("alert held low with no condition");

    cov_power_good: cover property ($rose(output_good_alias));
    cov_orderly_off: cover property (state == ST_HOLD ##1 state == ST_OFF);
    cov_hot_unplug: cover property (state == ST_RUN ##1 kill_eff);
    cov_start_fault: cover property (state == ST_RAMP ##1 state == ST_FAULT);

endmodule : pcs_sequencer
`default_nettype wire

//--- design/pcs_pkg.sv
// Shared timing constants and state encoding for the PSU control sequencer
package pcs_pkg;

    // Clock and timebase
    localparam int CLK_HZ = 25_000_000;
    localparam int CYC_PER_MS_DEF = CLK_HZ / 1000;
    localparam int MS_W = 10;

    // Unplug response: one clock is far below this bound
    localparam int T_KILL_US = 100;
    localparam int KILL_CYC = T_KILL_US * (CLK_HZ / 1_000_000);

    // Millisecond thresholds, compared against tick counters
    localparam logic [MS_W-1:0] T_ON_MIN_MS = 10'h005;
    localparam logic [MS_W-1:0] T_ON_MAX_MS = 10'h190;
    localparam logic [MS_W-1:0] T_PGOFF_MAX_MS = 10'h032;
    localparam logic [MS_W-1:0] T_GOOD_MIN_MS = 10'h064;
    localparam logic [MS_W-1:0] T_GOOD_MAX_MS = 10'h1F4;
    localparam logic [MS_W-1:0] T_GOOD_DLY_MS = 10'h096;
    localparam logic [MS_W-1:0] T_HOLD_MIN_MS = 10'h001;
    localparam logic [MS_W-1:0] T_HOLD_MAX_MS = 10'h0C8;
    localparam logic [MS_W-1:0] T_HOLD_MS = 10'h002;
    localparam logic [MS_W-1:0] T_PGLOW_MIN_MS = 10'h064;
    localparam logic [MS_W-1:0] MS_CNT_MAX = 10'h3FF;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFT,
        ST_RAMP,
        ST_RUN,
        ST_HOLD,
        ST_FAULT
    } pcs_state_t;

endpackage : pcs_pkg

//--- design/pcs_tick_div.sv
// Free-running millisecond tick divider
`timescale 1ns/100ps
`default_nettype none
module pcs_tick_div
    import pcs_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic ms_tick
);

    localparam logic [15:0] DIV_LAST = 16'(CYC_PER_MS - 1);

    logic [15:0] div_cnt;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt <= 16'h0000;
            ms_tick <= 1'b0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= 16'h0000;
            ms_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            ms_tick <= 1'b0;
        end
    end

endmodule : pcs_tick_div
`default_nettype wire

//--- test/pcs_sys_model.sv
// System board and converter stand-in for the PSU sequencer bench
`timescale 1ns/100ps
`default_nettype none
module pcs_sys_model #(
    parameter int CYC_PER_MS = 20
) (
    input wire logic ref_clk,
    input wire logic want_on,
    input wire logic mated,
    input wire logic main_on,
    input wire logic sag,
    input wire logic [3:0] ramp_ms,
    output logic enable_n,
    output logic enable_driven,
    output logic unplug_sense,
    output logic sense_driven,
    output logic main_in_reg
);
    int ramp_cnt;
    // Released enable line is read through its pull-up
    assign enable_driven = want_on;
    assign enable_n = !want_on;
    // Board grounds the mate; an unmated pin floats to its pull-up
    assign sense_driven = mated;
    assign unplug_sense = !mated;
    // Converter regulates ramp_ms after being enabled; sag drops it at once
    always_ff @(posedge ref_clk) begin
        if (!main_on || sag) begin
            ramp_cnt <= 0;
            main_in_reg <= 1'h0;
        end else if (ramp_cnt >= ramp_ms * CYC_PER_MS) begin
            main_in_reg <= 1'h1;
        end else begin
            ramp_cnt <= ramp_cnt + 1;
        end
    end
endmodule : pcs_sys_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the PSU control sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int C = 20;
    logic ref_clk, rst, want_on, mated, sag, cur_lim, int_fail, in_lost;
    logic opt_en, main_on, good, alert_n, enable_n, enable_driven, e;
    logic alert_q[$];
    logic unplug_sense, sense_driven, main_in_reg;
    logic [7:0] asrc;
    logic [3:0] ramp_ms;
    int errors, samples_checked, n, m;
    int cyc = 0;

    pcs_sys_model #(.CYC_PER_MS(C)) sys (.ref_clk(ref_clk),
        .want_on(want_on), .mated(mated), .main_on(main_on), .sag(sag),
        .ramp_ms(ramp_ms), .enable_n(enable_n), .enable_driven(enable_driven),
        .unplug_sense(unplug_sense), .sense_driven(sense_driven),
        .main_in_reg(main_in_reg));
    pcs_sequencer #(.CYC_PER_MS(C)) dut (.ref_clk(ref_clk), .rst(rst),
        .enable_n(enable_n), .enable_driven(enable_driven),
        .unplug_sense(unplug_sense), .sense_driven(sense_driven),
        .main_in_reg(main_in_reg), .current_limit(cur_lim),
        .internal_fail(int_fail), .input_lost(in_lost), .temp_warn(asrc[0]),
        .general_fail(asrc[1]), .over_current(asrc[2]),
        .over_voltage(asrc[3]), .under_voltage(asrc[4]), .fan_fail(asrc[5]),
        .end_of_life(asrc[6]), .env_exceeded(asrc[7]), .opt_alert_en(opt_en),
        .main_on(main_on), .output_good_alias(good), .fault_alert_n(alert_n));

    task automatic give_verdict;
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(string nm, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk
    task automatic rng(string nm, int lo, int hi, int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo,
                hi, got);
        end
    endtask : rng
    function automatic logic pick(int w);
        case (w)
            0: return main_on;
            1: return good;
            default: return main_in_reg;
        endcase
    endfunction : pick
    // Bounded wait; k counts falling edges until the level is seen
    task automatic wait_for(int w, logic v, int lim, output int k);
        k = 0;
        while (pick(w) !== v && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
    endtask : wait_for
    task automatic idle(int k);
        repeat (k) @(negedge ref_clk);
    endtask : idle

    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Roughly 24k cycles expected; generous ceiling
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        {rst, want_on, mated, sag, cur_lim, int_fail, in_lost, opt_en} = 8'h80;
        asrc = 8'h00;
        ramp_ms = 4'h2;
        void'($urandom(46867));
        idle(10);
        rst = 1'h0;
        chk("main_on", 1'h0, main_on);
        chk("power_good", 1'h0, good);
        repeat (40) begin
            asrc = 8'($urandom);
            opt_en = 1'($urandom);
            // Expected alert level from the listed causes
            alert_q.push_back(~(|asrc[5:0] | (opt_en & |asrc[7:6])));
            idle(2);
            e = alert_q.pop_front();
            chk("alert_n", e, alert_n);
        end
        asrc = 8'h00;
        idle(2);
        chk("alert_n", 1'h1, alert_n);
        mated = 1'h1;
        idle(8 * C);
        chk("main_on", 1'h0, main_on);
        {mated, want_on} = 2'h1;
        idle(8 * C);
        chk("main_on", 1'h0, main_on);
        mated = 1'h1;
        ramp_ms = 4'(1 + $urandom % 4);
        wait_for(0, 1'h1, 10 * C, n);
        rng("turn_on_clocks", 5 * C - 1, 6 * C + 2, n);
        chk("power_good", 1'h0, good);
        wait_for(2, 1'h1, 10 * C, n);
        wait_for(1, 1'h1, 510 * C, n);
        rng("good_delay", 149 * C - 1, 150 * C + 2, n);
        sag = 1'h1;
        idle(2);
        chk("power_good", 1'h0, good);
        // Limit held past the whole delay, so a leaky counter shows up here
        {sag, cur_lim} = 2'h1;
        idle(160 * C);
        chk("power_good", 1'h0, good);
        cur_lim = 1'h0;
        wait_for(1, 1'h1, 510 * C, n);
        rng("good_after_limit", 149 * C - 1, 150 * C + 2, n);
        in_lost = 1'h1;
        idle(2);
        chk("power_good", 1'h0, good);
        in_lost = 1'h0;
        wait_for(1, 1'h1, 510 * C, n);
        want_on = 1'h0;
        wait_for(1, 1'h0, 50 * C, n);
        rng("good_off_clocks", 0, 2, n);
        wait_for(0, 1'h0, 250 * C, m);
        rng("hold_clocks", 2 * C - 1, 3 * C + 2, m);
        want_on = 1'h1;
        wait_for(1, 1'h1, 700 * C, n);
        rng("good_low_clocks", 100 * C, 700 * C, n + m);
        int_fail = 1'h1;
        idle(3);
        chk("power_good", 1'h0, good);
        chk("main_on", 1'h0, main_on);
        chk("alert_n", 1'h0, alert_n);
        {want_on, int_fail} = 2'h0;
        idle(4);
        chk("alert_n", 1'h1, alert_n);
        // Converter never regulates: start-up gives up near 400 ms
        {want_on, sag} = 2'h3;
        wait_for(0, 1'h1, 10 * C, n);
        wait_for(0, 1'h0, 400 * C, n);
        rng("start_timeout", 393 * C, 396 * C, n);
        idle(2);
        chk("alert_n", 1'h0, alert_n);
        {want_on, sag} = 2'h0;
        idle(4);
        chk("alert_n", 1'h1, alert_n);
        want_on = 1'h1;
        wait_for(0, 1'h1, 10 * C, n);
        mated = 1'h0;
        wait_for(0, 1'h0, 100, n);
        rng("kill_clocks", 0, 2, n);
        chk("power_good", 1'h0, good);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
